// ==== verilog/mut_core.sv ====
// Purpose: Multiply and multiply-accumulate unit with cycle timing and interlock.
// Assumes: Decode presents operands on the A, B and C buses while start_i is high, or in the interlock cycle when one is inserted.
// Notes: Outputs reflect multiply cycle 1 one clock after the request is taken.
//
// Functional notes
// (RULE1) All but final cycle are internal
// (RULE2) Booth recode sixteen multiplier bits per cycle
// (RULE3) Operands read from A and B buses
// (RULE4) Memory stage adds accumulate and feedback
// (RULE5) Compressed state: plain multiply sets flags
// (RULE6) Dependent follower stalls one cycle
// (RULE7) Accumulate-only chaining never stalls
// (RULE8) Plain multiply two cycles, three interlocked
// (RULE9) Flag-setting plain multiply four cycles, nonstalling
// (RULE10) Long multiply three cycles, four interlocked
// (RULE11) Flag-setting long multiply five cycles always
// (RULE12) Halfword variants one cycle, two interlocked
// (RULE13) Halfword long accumulate two, three interlocked
// (RULE14) Fetch address held, final cycle sequential
// (RULE15) Interlock compares destination against decoded sources
// (RULE16) Flag-setting results finish before next Execute
`timescale 1ns/1ps
`default_nettype none
module mut_core
  import mut_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire mut_op_t op_i,
  input wire logic compressed_i,
  input wire logic sel_x_i,
  input wire logic sel_y_i,
  input wire logic [3:0] dest_lo_i,
  input wire logic [3:0] dest_hi_i,
  input wire logic [31:0] pc_i,
  input wire logic [31:0] a_bus_i,
  input wire logic [31:0] b_bus_i,
  input wire logic [31:0] c_bus_lo_i,
  input wire logic [31:0] c_bus_hi_i,
  input wire logic dec_valid_i,
  input wire logic dec_use_a_i,
  input wire logic dec_use_b_i,
  input wire logic dec_use_c_i,
  input wire logic dec_use_d_i,
  input wire logic [3:0] dec_src_a_i,
  input wire logic [3:0] dec_src_b_i,
  input wire logic [3:0] dec_src_c_i,
  input wire logic [3:0] dec_src_d_i,
  output logic [31:0] fetch_address_o,
  output logic fetch_request_n_o,
  output logic fetch_sequential_o,
  output logic operand_request_n_o,
  output logic operand_sequential_o,
  output logic ready_o,
  output logic busy_o,
  output logic stall_o,
  output logic illegal_o,
  output logic [63:0] result_o,
  output logic result_valid_o,
  output logic result_long_o,
  output logic [3:0] result_dest_lo_o,
  output logic [3:0] result_dest_hi_o,
  output logic [1:0] flags_o,
  output logic flags_valid_o
);

  // ----------------------------------------------------------------
  // State and datapath registers
  // ----------------------------------------------------------------
  mut_state_t state, next_state;
  mut_op_t op_q, next_op;
  logic [2:0] cnt, next_cnt;
  logic [2:0] total, next_total;
  logic sel_x, next_sel_x;
  logic sel_y, next_sel_y;
  logic [3:0] dlo, next_dlo;
  logic [3:0] dhi, next_dhi;
  logic [63:0] mcand, next_mcand;
  logic [31:0] mplier, next_mplier;
  logic [63:0] acc, next_acc;
  logic [31:0] next_fetch_address;
  logic next_fetch_request_n, next_fetch_sequential, next_ready, next_busy;
  logic next_stall, next_illegal, next_result_valid, next_result_long;
  logic next_flags_valid;
  logic [63:0] next_result;
  logic [1:0] next_flags;
  logic [3:0] next_result_dest_lo, next_result_dest_hi;

  // Decode-time terms, also watched by the checks below
  mut_op_t op_eff, cap_op;
  logic is_final, can_take, bad_op, take, hazard, hit_ab, hit_c, chain_ok, go_wait;
  logic do_step, capture, cap_sx, cap_sy, next_final;
  logic [2:0] step_idx;
  logic [63:0] acc_step, res_full;
  logic [31:0] c_lo, c_hi;

  mut_step_if stp ();

  mut_booth_step u_step (
    .stp(stp)
  );

  // ----------------------------------------------------------------
  // Next-value logic
  // ----------------------------------------------------------------
  always_comb
  begin
    // Compressed state has no flag-setting plain accumulate; its plain multiply sets flags
    op_eff = (compressed_i && op_i == product_op) ? product_op_flagset : op_i; // RULE5
    bad_op = compressed_i && op_i == product_accum_op_flagset; // RULE5
    is_final = (state == st_run) && (cnt == total);
    can_take = (state == st_idle) || is_final;
    take = start_i && can_take && !bad_op;

    // One 16-bit chunk per Execute cycle, feedback kept in acc
    step_idx = cnt - CNT_FIRST;
    do_step = (state == st_run) && (step_idx < (mut_is_half(op_q) ? 3'h1 : 3'h2));
    stp.mcand = mcand;
    stp.chunk = step_idx[0] ? mplier[31:16] : mplier[15:0]; // RULE2
    stp.chunk_signed = (step_idx[0] || mut_is_half(op_q)) && !mut_is_unsigned(op_q);
    acc_step = acc;
    if (do_step)
      acc_step = acc + (step_idx[0] ? {stp.partial[47:0], 16'h0000} : stp.partial); // RULE4

    // Word-by-half keeps the upper 32 bits of a 48-bit product
    res_full = mut_is_wbh(op_q) ? {{16{acc_step[63]}}, acc_step[63:16]} : acc_step;
    if (!mut_is_long(op_q))
      res_full = {32'h0000_0000, res_full[31:0]};

    // Hazard against the instruction now in decode; only in our final cycle
    hit_ab = (dec_use_a_i && (dec_src_a_i == dlo || (mut_is_long(op_q) && dec_src_a_i == dhi)))
      || (dec_use_b_i && (dec_src_b_i == dlo || (mut_is_long(op_q) && dec_src_b_i == dhi)));
    hit_c = (dec_use_c_i && (dec_src_c_i == dlo || (mut_is_long(op_q) && dec_src_c_i == dhi)))
      || (dec_use_d_i && (dec_src_d_i == dlo || (mut_is_long(op_q) && dec_src_d_i == dhi)));
    chain_ok = take && mut_is_accum(op_eff); // RULE7
    hazard = dec_valid_i && is_final && !mut_is_flagset(op_q)
      && (hit_ab || (hit_c && !chain_ok)); // RULE15 RULE16
    go_wait = take && hazard && !mut_is_flagset(op_eff); // RULE9 RULE11

    // Chained accumulate takes the finishing result instead of the C bus
    c_lo = (chain_ok && is_final && dec_use_c_i && dec_src_c_i == dlo)
      ? res_full[31:0] : c_bus_lo_i; // RULE7
    c_hi = (chain_ok && is_final && dec_use_d_i && dec_src_d_i == dhi)
      ? res_full[63:32] : c_bus_hi_i;

    // Defaults hold state; acc takes the step sum
    next_state = state;
    next_op = op_q;
    next_cnt = cnt;
    next_total = total;
    next_sel_x = sel_x;
    next_sel_y = sel_y;
    next_dlo = dlo;
    next_dhi = dhi;
    next_mcand = mcand;
    next_mplier = mplier;
    next_acc = acc_step;
    next_fetch_address = fetch_address_o;

    unique case (state)
      st_idle: next_state = st_idle;
      st_wait:
      begin
        // Interlock cycle spent, operands now valid in the register file
        next_state = st_run;
        next_cnt = CNT_FIRST;
      end
      st_run:
      begin
        if (is_final)
          next_state = st_idle;
        else
          next_cnt = cnt + CNT_FIRST;
      end
      default: next_state = st_idle;
    endcase

    if (take)
    begin
      next_op = op_eff;
      next_sel_x = sel_x_i;
      next_sel_y = sel_y_i;
      next_dlo = dest_lo_i;
      next_dhi = dest_hi_i;
      next_total = mut_base_cycles(op_eff); // RULE8 RULE9 RULE10 RULE11 RULE12 RULE13
      next_fetch_address = pc_i + (compressed_i ? FETCH_AHEAD_NARROW : FETCH_AHEAD_WIDE); // RULE14
      next_state = go_wait ? st_wait : st_run; // RULE8 RULE10 RULE12 RULE13
      next_cnt = go_wait ? 3'h0 : CNT_FIRST;
    end

    // Operand capture from the A, B and C buses at the start of Execute
    capture = (state == st_wait) || (take && !go_wait);
    cap_op = take ? op_eff : op_q;
    cap_sx = take ? sel_x_i : sel_x;
    cap_sy = take ? sel_y_i : sel_y;
    if (capture)
    begin
      next_mplier = b_bus_i; // RULE3
      next_mcand = (mut_is_unsigned(cap_op)) ? {32'h0000_0000, a_bus_i}
        : {{32{a_bus_i[31]}}, a_bus_i}; // RULE3
      next_acc = RESET_WORD;
      if (mut_is_half(cap_op))
      begin
        next_mplier = {16'h0000, cap_sy ? b_bus_i[31:16] : b_bus_i[15:0]};
        if (!mut_is_wbh(cap_op))
          next_mcand = cap_sx ? {{48{a_bus_i[31]}}, a_bus_i[31:16]}
            : {{48{a_bus_i[15]}}, a_bus_i[15:0]};
      end
      if (mut_is_accum(cap_op))
      begin
        if (mut_is_long(cap_op))
          next_acc = {c_hi, c_lo}; // RULE4
        else if (mut_is_wbh(cap_op))
          next_acc = {{16{c_lo[31]}}, c_lo, 16'h0000};
        else if (mut_is_half(cap_op))
          next_acc = {{32{c_lo[31]}}, c_lo};
        else
          next_acc = {32'h0000_0000, c_lo};
      end
    end

    // Port values for the coming cycle
    next_final = (next_state == st_run) && (next_cnt == next_total);
    next_busy = next_state != st_idle;
    next_ready = (next_state == st_idle) || next_final;
    next_fetch_request_n = !next_final; // RULE1 RULE14
    next_fetch_sequential = next_final; // RULE14
    next_stall = hazard && !take; // RULE6
    next_illegal = start_i && can_take && bad_op;

    // Result lands at the end of Memory, one clock after the final cycle
    next_result_valid = is_final; // RULE6
    next_result = is_final ? res_full : result_o;
    next_result_long = is_final ? mut_is_long(op_q) : result_long_o;
    next_result_dest_lo = is_final ? dlo : result_dest_lo_o;
    next_result_dest_hi = is_final ? dhi : result_dest_hi_o;
    next_flags_valid = is_final && mut_is_flagset(op_q); // RULE16
    next_flags = flags_o;
    if (is_final && mut_is_flagset(op_q))
      next_flags = mut_is_long(op_q) ? {res_full[63], res_full == RESET_WORD}
        : {res_full[31], res_full[31:0] == 32'h0000_0000};
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state <= st_idle;
      op_q <= product_op;
      cnt <= 3'h0;
      total <= CYC_HALF;
      sel_x <= 1'b0;
      sel_y <= 1'b0;
      dlo <= RESET_REG;
      dhi <= RESET_REG;
      mcand <= RESET_WORD;
      mplier <= 32'h0000_0000;
      acc <= RESET_WORD;
      fetch_address_o <= 32'h0000_0000;
      fetch_request_n_o <= 1'b1;
      fetch_sequential_o <= 1'b0;
      operand_request_n_o <= 1'b1;
      operand_sequential_o <= 1'b0;
      ready_o <= 1'b1;
      busy_o <= 1'b0;
      stall_o <= 1'b0;
      illegal_o <= 1'b0;
      result_o <= RESET_WORD;
      result_valid_o <= 1'b0;
      result_long_o <= 1'b0;
      result_dest_lo_o <= RESET_REG;
      result_dest_hi_o <= RESET_REG;
      flags_o <= 2'h0;
      flags_valid_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      op_q <= next_op;
      cnt <= next_cnt;
      total <= next_total;
      sel_x <= next_sel_x;
      sel_y <= next_sel_y;
      dlo <= next_dlo;
      dhi <= next_dhi;
      mcand <= next_mcand;
      mplier <= next_mplier;
      acc <= next_acc;
      fetch_address_o <= next_fetch_address;
      fetch_request_n_o <= next_fetch_request_n;
      fetch_sequential_o <= next_fetch_sequential;
      operand_request_n_o <= 1'b1; // RULE14
      operand_sequential_o <= 1'b0;
      ready_o <= next_ready;
      busy_o <= next_busy;
      stall_o <= next_stall;
      illegal_o <= next_illegal;
      result_o <= next_result;
      result_valid_o <= next_result_valid;
      result_long_o <= next_result_long;
      result_dest_lo_o <= next_result_dest_lo;
      result_dest_hi_o <= next_result_dest_hi;
      flags_o <= next_flags;
      flags_valid_o <= next_flags_valid;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_int;
    busy_o && fetch_request_n_o && !fetch_sequential_o;
  endsequence
  sequence s_end;
    busy_o && !fetch_request_n_o && fetch_sequential_o;
  endsequence

  property p_data_idle;
    busy_o |-> operand_request_n_o && !operand_sequential_o && (fetch_request_n_o != fetch_sequential_o);
  endproperty
  a_data_idle: assert property (p_data_idle) else $error("data port left internal state"); // RULE1
  property p_plain;
    take && (op_eff inside {product_op, product_accum_op}) && !go_wait |=> s_int ##1 s_end;
  endproperty
  a_plain: assert property (p_plain) else $error("plain multiply not two cycles"); // RULE8
  property p_plain_il;
    go_wait && (op_eff inside {product_op, product_accum_op}) |=> s_int [*2] ##1 s_end;
  endproperty
  a_plain_il: assert property (p_plain_il) else $error("interlocked multiply not three cycles"); // RULE8
  property p_flag;
    take && mut_is_flagset(op_eff) && !mut_is_long(op_eff) |=> s_int [*3] ##1 s_end;
  endproperty
  a_flag: assert property (p_flag) else $error("flag multiply not four cycles"); // RULE9
  property p_long_il;
    go_wait && mut_is_long(op_eff) && !mut_is_half(op_eff) |=> s_int [*3] ##1 s_end;
  endproperty
  a_long_il: assert property (p_long_il) else $error("interlocked long multiply not four cycles"); // RULE10
  property p_long_flag;
    take && mut_is_flagset(op_eff) && mut_is_long(op_eff) |=> s_int [*4] ##1 s_end;
  endproperty
  a_long_flag: assert property (p_long_flag) else $error("flag long multiply not five cycles"); // RULE11
  property p_half;
    take && mut_is_half(op_eff) && op_eff != halfword_long_product_accum && !go_wait |=> s_end;
  endproperty
  a_half: assert property (p_half) else $error("halfword multiply not one cycle"); // RULE12
  property p_half_long;
    take && op_eff == halfword_long_product_accum && !go_wait |=> s_int ##1 s_end;
  endproperty
  a_half_long: assert property (p_half_long) else $error("halfword long accumulate not two cycles"); // RULE13
  property p_hold;
    s_int |=> $stable(fetch_address_o);
  endproperty
  a_hold: assert property (p_hold) else $error("fetch address moved during multiply"); // RULE14
  property p_stall;
    is_final && mut_is_flagset(op_q) |=> !stall_o && result_valid_o && flags_valid_o ##1 !stall_o;
  endproperty
  a_stall: assert property (p_stall) else $error("flag multiply stalled its follower"); // RULE16
  property p_chain;
    chain_ok && dec_valid_i && !hit_ab |=> state != st_wait && !stall_o;
  endproperty
  a_chain: assert property (p_chain) else $error("chained accumulate was interlocked"); // RULE7
  property p_bad;
    start_i && can_take && bad_op |=> illegal_o && !busy_o;
  endproperty
  a_bad: assert property (p_bad) else $error("compressed flag accumulate was accepted"); // RULE5

endmodule
`default_nettype wire

// ==== shared/mut_pkg.sv ====
// Purpose: Shared constants, operation codes and helpers of the multiply timing unit.
// Assumes: One core clock; operation codes come from the decode stage.
// Notes: Cycle figures are counted in Execute cycles of the multiply itself.
package mut_pkg;

  // ----------------------------------------------------------------
  // Datapath geometry
  // ----------------------------------------------------------------
  localparam int CHUNK_W = 16;
  localparam int BOOTH_DIGITS = 9;

  // ----------------------------------------------------------------
  // Cycle counts per variant, without interlock
  // ----------------------------------------------------------------
  localparam logic [2:0] CYC_HALF = 3'h1;
  localparam logic [2:0] CYC_PLAIN = 3'h2;
  localparam logic [2:0] CYC_HALF_LONG = 3'h2;
  localparam logic [2:0] CYC_LONG = 3'h3;
  localparam logic [2:0] CYC_FLAG = 3'h4;
  localparam logic [2:0] CYC_LONG_FLAG = 3'h5;
  localparam logic [2:0] CNT_FIRST = 3'h1;

  // ----------------------------------------------------------------
  // Fetch look-ahead (three instructions) and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] FETCH_AHEAD_WIDE = 32'h0000_000C;
  localparam logic [31:0] FETCH_AHEAD_NARROW = 32'h0000_0006;
  localparam logic [63:0] RESET_WORD = 64'h0000_0000_0000_0000;
  localparam logic [3:0] RESET_REG = 4'h0;

  typedef enum logic [4:0] {
    product_op = 5'h00,
    product_accum_op = 5'h01,
    product_op_flagset = 5'h02,
    product_accum_op_flagset = 5'h03,
    signed_long_product = 5'h04,
    unsigned_long_product = 5'h05,
    signed_long_product_accum = 5'h06,
    unsigned_long_product_accum = 5'h07,
    signed_long_product_flagset = 5'h08,
    unsigned_long_product_flagset = 5'h09,
    signed_long_accum_flagset = 5'h0A,
    unsigned_long_accum_flagset = 5'h0B,
    halfword_product = 5'h0C,
    halfword_product_accum = 5'h0D,
    word_by_half_product = 5'h0E,
    word_by_half_product_accum = 5'h0F,
    halfword_long_product_accum = 5'h10
  } mut_op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait = 2'b01,
    st_run = 2'b10
  } mut_state_t;

  // ----------------------------------------------------------------
  // Variant classification
  // ----------------------------------------------------------------
  function automatic logic mut_is_flagset(input mut_op_t op);
    return op inside {product_op_flagset, product_accum_op_flagset,
      signed_long_product_flagset, unsigned_long_product_flagset,
      signed_long_accum_flagset, unsigned_long_accum_flagset};
  endfunction

  function automatic logic mut_is_long(input mut_op_t op);
    return (op >= signed_long_product && op <= unsigned_long_accum_flagset)
      || op == halfword_long_product_accum;
  endfunction

  function automatic logic mut_is_unsigned(input mut_op_t op);
    return op inside {unsigned_long_product, unsigned_long_product_accum,
      unsigned_long_product_flagset, unsigned_long_accum_flagset};
  endfunction

  function automatic logic mut_is_accum(input mut_op_t op);
    return op inside {product_accum_op, product_accum_op_flagset,
      signed_long_product_accum, unsigned_long_product_accum,
      signed_long_accum_flagset, unsigned_long_accum_flagset,
      halfword_product_accum, word_by_half_product_accum, halfword_long_product_accum};
  endfunction

  // Single-chunk variants: multiplier is one halfword
  function automatic logic mut_is_half(input mut_op_t op);
    return op >= halfword_product;
  endfunction

  function automatic logic mut_is_wbh(input mut_op_t op);
    return op inside {word_by_half_product, word_by_half_product_accum};
  endfunction

  function automatic logic [2:0] mut_base_cycles(input mut_op_t op);
    if (op == halfword_long_product_accum)
      return CYC_HALF_LONG;
    if (mut_is_half(op))
      return CYC_HALF;
    if (mut_is_long(op))
      return mut_is_flagset(op) ? CYC_LONG_FLAG : CYC_LONG;
    return mut_is_flagset(op) ? CYC_FLAG : CYC_PLAIN;
  endfunction

endpackage

// ==== shared/mut_step_if.sv ====
// Purpose: Carries one multiplier chunk and its partial product between modules.
// Assumes: Purely combinational path inside one clock cycle.
// Notes: The driving side owns operands, the step side owns the sum.
`timescale 1ns/1ps
`default_nettype none
interface mut_step_if;
  logic [63:0] mcand;
  logic [15:0] chunk;
  logic chunk_signed;
  logic [63:0] partial;
  modport drive (output mcand, output chunk, output chunk_signed, input partial);
  modport step (input mcand, input chunk, input chunk_signed, output partial);
endinterface
`default_nettype wire

// ==== verilog/mut_booth_step.sv ====
// Purpose: Radix-4 recoding of one 16-bit multiplier chunk and partial product sum.
// Assumes: Multiplicand already extended to 64 bits by the caller.
// Notes: Two's complement wrap at 64 bits is intended.
`timescale 1ns/1ps
`default_nettype none
module mut_booth_step
  import mut_pkg::*;
(
  mut_step_if.step stp
);

  // ----------------------------------------------------------------
  // Recode and sum; a signed chunk extends its sign into the top digit
  // ----------------------------------------------------------------
  always_comb
  begin : booth_sum
    logic [18:0] ybits;
    logic [63:0] sum;
    logic [63:0] term;
    ybits = {{2{stp.chunk_signed & stp.chunk[15]}}, stp.chunk, 1'b0};
    sum = RESET_WORD;
    term = RESET_WORD;
    for (int i = 0; i < BOOTH_DIGITS; i++)
    begin
      case (ybits[2*i +: 3])
        3'b001, 3'b010: term = stp.mcand;
        3'b011: term = stp.mcand << 1;
        3'b100: term = -(stp.mcand << 1);
        3'b101, 3'b110: term = -stp.mcand;
        default: term = RESET_WORD;
      endcase
      sum = sum + (term << (2 * i)); // RULE2
    end
    stp.partial = sum;
  end

endmodule
`default_nettype wire

// ==== tb/mut_regfile_model.sv ====
// Purpose: Register file model that feeds the A, B and C operand buses.
// Assumes: Reads are combinational within one core cycle.
// Notes: Every register holds a spread pattern so each Booth chunk is busy.
`timescale 1ns/1ps
`default_nettype none
module mut_regfile_model (
  input wire logic [3:0] ra_i,
  input wire logic [3:0] rb_i,
  input wire logic [3:0] rc_i,
  output logic [31:0] a_o,
  output logic [31:0] b_o,
  output logic [31:0] c_o,
  output logic [31:0] c_hi_o
);
  // ----------------------------------------------------------------
  // Read ports
  // ----------------------------------------------------------------
  assign a_o = 32'h0003_0001 * {28'h000_0000, ra_i} + 32'h8001_0007;
  assign b_o = 32'h0003_0001 * {28'h000_0000, rb_i} + 32'h8001_0007;
  assign c_o = 32'h0003_0001 * {28'h000_0000, rc_i} + 32'h8001_0007;
  assign c_hi_o = ~c_o; // High word differs so a swapped half shows
endmodule
`default_nettype wire

// ==== tb/multiply_unit_timing_tb.sv ====
// Purpose: Self-checking bench of the multiply timing unit.
// Assumes: Inputs change on the falling clock edge.
// Notes: Dependent followers are presented in the final multiply cycle.
`timescale 1ns/1ps
`default_nettype none
module multiply_unit_timing_tb;
  import mut_pkg::*;
  logic clk_i = 0, reset_i = 1, start_i = 0, compressed_i = 0, sel_x_i = 0, sel_y_i = 0;
  logic dec_valid_i = 0, dec_use_a_i = 0, dec_use_b_i = 0, dec_use_c_i = 0, dec_use_d_i = 0;
  mut_op_t op_i = product_op;
  logic [3:0] dest_lo_i = 4'h3, dest_hi_i = 4'h9, dec_src_a_i = 0, dec_src_b_i = 0;
  logic [3:0] dec_src_c_i = 0, dec_src_d_i = 0, ra = 4'h1, rb = 4'h2, rc = 4'h4;
  logic [31:0] pc_i = 32'h0000_1000, a_bus_i, b_bus_i, c_bus_lo_i, c_bus_hi_i, fetch_address_o;
  logic fetch_request_n_o, fetch_sequential_o, operand_request_n_o, operand_sequential_o;
  logic ready_o, busy_o, stall_o, illegal_o, result_valid_o, result_long_o, flags_valid_o;
  logic [63:0] result_o;
  logic [3:0] result_dest_lo_o, result_dest_hi_o;
  logic [1:0] flags_o;
  int miscompares = 0, samples_checked = 0;
  int cyc[17] = '{2, 2, 4, 4, 3, 3, 3, 3, 5, 5, 5, 5, 1, 1, 1, 1, 2};

  // ----------------------------------------------------------------
  // Clock, design and register file
  // ----------------------------------------------------------------
  initial forever #25 clk_i = ~clk_i;
  mut_core i_mut_core (.clk_i, .reset_i, .start_i, .op_i, .compressed_i, .sel_x_i, .sel_y_i,
    .dest_lo_i, .dest_hi_i, .pc_i, .a_bus_i, .b_bus_i, .c_bus_lo_i, .c_bus_hi_i, .dec_valid_i,
    .dec_use_a_i, .dec_use_b_i, .dec_use_c_i, .dec_use_d_i, .dec_src_a_i, .dec_src_b_i,
    .dec_src_c_i, .dec_src_d_i, .fetch_address_o, .fetch_request_n_o, .fetch_sequential_o,
    .operand_request_n_o, .operand_sequential_o, .ready_o, .busy_o, .stall_o, .illegal_o,
    .result_o, .result_valid_o, .result_long_o, .result_dest_lo_o, .result_dest_hi_o,
    .flags_o, .flags_valid_o);
  mut_regfile_model i_mut_regfile_model (.ra_i(ra), .rb_i(rb), .rc_i(rc), .a_o(a_bus_i),
    .b_o(b_bus_i), .c_o(c_bus_lo_i), .c_hi_o(c_bus_hi_i));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] regv(input logic [3:0] k);
    return 32'h0003_0001 * {28'h000_0000, k} + 32'h8001_0007;
  endfunction

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Present a request for one edge; the unit must be ready at that edge
  task automatic go(input mut_op_t op, input logic comp);
    start_i = 1'b1;
    op_i = op;
    compressed_i = comp;
    @(negedge clk_i);
    start_i = 1'b0;
  endtask

  // Count busy cycles and judge the fetch and data ports in each of them
  task automatic run(input int exp);
    int n;
    n = 0;
    while (busy_o === 1'b1 && n < 9)
    begin
      check("fetch_address", fetch_address_o, pc_i + (compressed_i ? 6 : 12));
      check("fetch_request_n", fetch_request_n_o, n != exp - 1);
      check("fetch_sequential", fetch_sequential_o, n == exp - 1);
      check("operand_request_n", operand_request_n_o, 1'b1);
      check("ready", ready_o, n == exp - 1);
      n++;
      @(negedge clk_i);
    end
    check("busy_cycles", n, exp);
    check("result_valid", result_valid_o, 1'b1);
    check("dest", {result_dest_hi_o, result_dest_lo_o}, {dest_hi_i, dest_lo_i});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every variant alone, with product values for plain, accumulate and long
  task automatic t_table();
    logic [63:0] exp;
    logic [63:0] av;
    logic [63:0] bv;
    for (int k = 0; k < 17; k++)
    begin
      go(mut_op_t'(k), 1'b0);
      run(cyc[k]);
      // Signed variants extend the operand sign; the unsigned long one does not
      av = (k == 5) ? {32'h0000_0000, regv(ra)} : 64'($signed(regv(ra)));
      bv = (k == 5) ? {32'h0000_0000, regv(rb)} : 64'($signed(regv(rb)));
      exp = av * bv + ((k == 1 || k == 3) ? {32'h0000_0000, regv(rc)} : RESET_WORD);
      if (k < 4)
        exp[63:32] = 32'h0000_0000;
      if (k < 6)
        check("result", result_o, exp);
      if (k == 2 || k == 3)
        check("flags", {flags_valid_o, flags_o}, {1'b1, exp[31], ~|exp[31:0]});
      check("result_long", result_long_o, k inside {[4:11], 16});
    end
  endtask

  // First op runs to its final cycle, where a follower reading its result decodes
  task automatic dep(input mut_op_t op1, input mut_op_t op2, input logic st, input logic use_c,
    input int exp);
    go(op1, 1'b0);
    for (int i = 0; i < 8 && ready_o !== 1'b1; i++)
      @(negedge clk_i);
    dec_valid_i = 1'b1;
    dec_use_a_i = !use_c;
    dec_use_b_i = 1'b1;
    dec_use_c_i = use_c;
    dec_src_a_i = dest_lo_i;
    dec_src_b_i = dest_lo_i ^ 4'h1;
    dec_src_c_i = dest_lo_i;
    start_i = st;
    op_i = op2;
    @(negedge clk_i);
    dec_valid_i = 1'b0;
    start_i = 1'b0;
    if (st)
      run(exp);
    else
      check("stall", stall_o, exp);
  endtask

  // Compressed state: plain multiply sets flags, flag accumulate refused
  task automatic t_compressed();
    go(product_op, 1'b1);
    run(4);
    check("flags_valid", flags_valid_o, 1'b1);
    go(product_accum_op_flagset, 1'b1);
    check("illegal", illegal_o, 1'b1);
    check("busy_refused", busy_o, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(negedge clk_i);
    reset_i = 1'b0;
    check("ready_reset", {ready_o, busy_o, fetch_request_n_o}, 3'b101);
    t_table();
    dep(product_op, product_op, 1'b1, 1'b0, 3);
    dep(product_op, signed_long_product, 1'b1, 1'b0, 4);
    dep(product_op, halfword_product, 1'b1, 1'b0, 2);
    dep(product_op, halfword_long_product_accum, 1'b1, 1'b0, 3);
    dep(product_op, product_accum_op, 1'b1, 1'b1, 2);
    check("chain", result_o, {32'h0000_0000, regv(ra) * regv(rb) << 1});
    dep(product_op, product_op, 1'b0, 1'b0, 1);
    dep(product_op_flagset, product_op, 1'b0, 1'b0, 0);
    dep(unsigned_long_product_flagset, product_op, 1'b1, 1'b0, 2);
    t_compressed();
    end_sim();
  end

  // Whole run is under two hundred cycles; this span is well beyond it
  initial
  begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
